// >>> hdl/bit_branch_loop_cpu_control.sv
// Execution unit for bit-test branch, counted loop and CPU control instructions
//
// Overview of operation
// - Bit clear: PC becomes next-instruction address plus signed displacement; length 4 or 3.
// - Bit set: nothing else happens, execution continues sequentially.
// - Loop instruction decrements B, C or a short-address byte in place.
// - Nonzero result branches relative to next address; length 2 or 3 bytes.
// - No-operation changes nothing and only takes its execution time.
// - Interrupt enable instruction sets the maskable interrupt enable flag.
// - After interrupt enable, a pending interrupt is taken at the next boundary.
// - Interrupt disable instruction clears the maskable interrupt enable flag.
// - No interrupt of any kind is taken right after interrupt disable.
// - Halt stops the CPU operation clock; the rest keeps running.
// - Stop halts the main oscillator and the whole system.
`timescale 1ns/1ns
`default_nettype none
module bit_branch_loop_cpu_control
    import exec_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic int_req,
    input wire logic nmi_req,
    output logic int_ack,
    output logic nmi_ack,
    output logic cpu_clk_stop,
    output logic osc_stop
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [2:0] word_index(input logic [7:0] addr);
        return addr[4:2];
    endfunction : word_index

    function automatic logic [2:0] byte_index(input logic [7:0] addr);
        return addr[2:0];
    endfunction : byte_index

    function automatic logic bit_of(input logic [7:0] value, input logic [2:0] pos);
        return value[pos];
    endfunction : bit_of

    // ****************************************
    // Declarations
    // ****************************************
    state_t state_q;
    state_t state_d;
    op_t op_q;
    op_t dec_op;
    logic [2:0] dec_len;
    logic [7:0] dec_b0;
    logic [7:0] dec_b1;
    logic [7:0] ibuf_q [0:3];
    logic [1:0] cnt_q;
    logic [7:0] disp_q;
    logic last_byte;
    logic [7:0] a_q;
    logic [7:0] b_q;
    logic [7:0] c_q;
    logic ien_q;
    logic z_q;
    logic aux_q;
    logic cry_q;
    logic [7:0] saddr_q [0:MEM_DEPTH-1];
    logic [7:0] sfr_q [0:MEM_DEPTH-1];
    logic run_q;
    logic wake_q;
    logic illegal_q;
    logic [7:0] psb_byte;
    logic [7:0] dec_src;
    logic [7:0] dec_val;
    logic is_loop;
    logic take;
    logic ien_next;
    logic ien_eff;
    logic ack_window;
    logic [15:0] target;
    logic busy;
    logic reg_hit;
    logic reg_locked;
    logic [31:0] rd_val;
    logic apb_wr;
    logic in_saddr;
    logic in_sfr;
    logic exec_q;

    // ****************************************
    // Instruction fetch
    // ****************************************
    assign dec_b0 = (cnt_q == 2'h0) ? prog_data : ibuf_q[0];
    assign dec_b1 = (cnt_q == 2'h1) ? prog_data : ibuf_q[1];
    assign last_byte = (state_q == ST_FETCH) && (({1'b0, cnt_q} + 3'h1) == dec_len);
    assign exec_q = (state_q == ST_EXEC);

    inst_decode u_decode (
        .b0(dec_b0),
        .b1(dec_b1),
        .op(dec_op),
        .len(dec_len)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prog_addr <= PC_RESET;
            cnt_q <= 2'h0;
            op_q <= OP_NOP;
            disp_q <= 8'h00;
        end else if (state_q == ST_FETCH) begin
            ibuf_q[cnt_q] <= prog_data;
            prog_addr <= prog_addr + 16'h0001;
            if (last_byte) begin
                cnt_q <= 2'h0;
                op_q <= dec_op;
                disp_q <= prog_data;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end else if (exec_q && take) begin
            prog_addr <= target;
        end else if (apb_wr && paddr == OFS_PC) begin
            prog_addr <= pwdata[15:0];
        end
    end

    // ****************************************
    // Execute datapath
    // ****************************************
    // Address after the instruction is the fetch pointer during execute
    assign target = prog_addr + {{8{disp_q[7]}}, disp_q};
    assign dec_val = dec_src - 8'h01;

    always_comb begin
        psb_byte = 8'h00;
        psb_byte[PSB_IEN_BIT] = ien_q;
        psb_byte[PSB_Z_BIT] = z_q;
        psb_byte[PSB_AUX_BIT] = aux_q;
        psb_byte[PSB_CRY_BIT] = cry_q;
    end

    always_comb begin
        take = 1'b0;
        is_loop = 1'b0;
        dec_src = 8'h00;
        ien_next = ien_q;
        case (op_q)
            OP_BCLR_SADDR: take = ~bit_of(saddr_q[byte_index(ibuf_q[2])], ibuf_q[1][2:0]);
            OP_BCLR_SFR: take = ~bit_of(sfr_q[byte_index(ibuf_q[2])], ibuf_q[1][2:0]);
            OP_BCLR_A: take = ~bit_of(a_q, ibuf_q[1][2:0]);
            OP_BCLR_PSB: take = ~bit_of(psb_byte, ibuf_q[1][2:0]);
            OP_LOOP_B: begin
                is_loop = 1'b1;
                dec_src = b_q;
            end
            OP_LOOP_C: begin
                is_loop = 1'b1;
                dec_src = c_q;
            end
            OP_LOOP_SADDR: begin
                is_loop = 1'b1;
                dec_src = saddr_q[byte_index(ibuf_q[1])];
            end
            OP_IEN: ien_next = 1'b1;
            OP_IDS: ien_next = 1'b0;
            OP_NOP: take = 1'b0;
            default: take = 1'b0;
        endcase
        if (is_loop) begin
            take = (dec_val != 8'h00);
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (run_q) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (last_byte) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                case (op_q)
                    OP_HALT: state_d = ST_HALT;
                    OP_STOP: state_d = ST_STOP;
                    default: state_d = run_q ? ST_FETCH : ST_IDLE;
                endcase
            end
            ST_HALT: begin
                if (wake_q || nmi_req || (int_req && ien_q)) begin
                    state_d = run_q ? ST_FETCH : ST_IDLE;
                end
            end
            ST_STOP: begin
                if (wake_q) begin
                    state_d = run_q ? ST_FETCH : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cpu_clk_stop <= 1'b0;
            osc_stop <= 1'b0;
        end else begin
            state_q <= state_d;
            cpu_clk_stop <= (state_d == ST_HALT);
            osc_stop <= (state_d == ST_STOP);
        end
    end

    // ****************************************
    // Interrupt acknowledge at boundaries
    // ****************************************
    // Enable seen by the boundary right after the enable instruction itself
    assign ien_eff = exec_q ? ien_next : ien_q;
    assign ack_window = (exec_q && op_q != OP_IDS && op_q != OP_HALT && op_q != OP_STOP)
        || (state_q == ST_HALT && state_d != ST_HALT);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            nmi_ack <= 1'b0;
            int_ack <= 1'b0;
        end else begin
            nmi_ack <= ack_window && nmi_req;
            int_ack <= ack_window && !nmi_req && int_req && ien_eff;
        end
    end

    // ****************************************
    // Register file and flags
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            a_q <= REG_RESET;
            b_q <= REG_RESET;
            c_q <= REG_RESET;
            ien_q <= 1'b0;
            z_q <= 1'b0;
            aux_q <= 1'b0;
            cry_q <= 1'b0;
        end else if (exec_q) begin
            ien_q <= ien_next;
            if (op_q == OP_LOOP_B) begin
                b_q <= dec_val;
            end
            if (op_q == OP_LOOP_C) begin
                c_q <= dec_val;
            end
        end else if (apb_wr && paddr == OFS_REGS) begin
            // Arithmetic flags change only by software, never by execution
            a_q <= pwdata[7:0];
            b_q <= pwdata[REGS_B_LSB +: 8];
            c_q <= pwdata[REGS_C_LSB +: 8];
            ien_q <= pwdata[REGS_PSB_LSB + PSB_IEN_BIT];
            z_q <= pwdata[REGS_PSB_LSB + PSB_Z_BIT];
            aux_q <= pwdata[REGS_PSB_LSB + PSB_AUX_BIT];
            cry_q <= pwdata[REGS_PSB_LSB + PSB_CRY_BIT];
        end
    end

    for (genvar gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
        always_ff @(posedge core_clk) begin
            if (reset) begin
                saddr_q[gi] <= MEM_RESET;
                sfr_q[gi] <= MEM_RESET;
            end else begin
                if (exec_q && op_q == OP_LOOP_SADDR && byte_index(ibuf_q[1]) == 3'(gi)) begin
                    saddr_q[gi] <= dec_val;
                end else if (apb_wr && in_saddr && word_index(paddr) == 3'(gi)) begin
                    saddr_q[gi] <= pwdata[7:0];
                end
                if (apb_wr && in_sfr && word_index(paddr) == 3'(gi)) begin
                    sfr_q[gi] <= pwdata[7:0];
                end
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign busy = (state_q != ST_IDLE);
    assign in_saddr = ((paddr & MEM_REGION_MASK) == SADDR_BASE);
    assign in_sfr = ((paddr & MEM_REGION_MASK) == SFR_BASE);
    assign apb_wr = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        rd_val = 32'h00000000;
        reg_hit = 1'b1;
        reg_locked = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            reg_hit = 1'b0;
        end else if (in_saddr) begin
            rd_val[7:0] = saddr_q[word_index(paddr)];
            reg_locked = busy;
        end else if (in_sfr) begin
            rd_val[7:0] = sfr_q[word_index(paddr)];
            reg_locked = busy;
        end else begin
            case (paddr)
                OFS_CTRL: rd_val[CTRL_RUN_BIT] = run_q;
                OFS_STATUS: begin
                    rd_val[STAT_BUSY_BIT] = busy;
                    rd_val[STAT_HALT_BIT] = (state_q == ST_HALT);
                    rd_val[STAT_STOP_BIT] = (state_q == ST_STOP);
                    rd_val[STAT_IEN_BIT] = ien_q;
                    rd_val[STAT_ILLEGAL_BIT] = illegal_q;
                end
                OFS_PC: begin
                    rd_val[15:0] = prog_addr;
                    reg_locked = busy;
                end
                OFS_REGS: begin
                    rd_val = {psb_byte, c_q, b_q, a_q};
                    reg_locked = busy;
                end
                default: reg_hit = 1'b0;
            endcase
        end
    end

    // Answer is prepared at setup, so every access has zero wait states
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (!reg_hit || (pwrite && reg_locked));
            prdata <= (psel && !penable && !pwrite && reg_hit) ? rd_val : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            run_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= apb_wr && paddr == OFS_CTRL && pwdata[CTRL_WAKE_BIT];
            if (apb_wr && paddr == OFS_CTRL) begin
                run_q <= pwdata[CTRL_RUN_BIT];
            end
        end
    end

    // Undefined opcode flag: a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            illegal_q <= 1'b0;
        end else if (exec_q && op_q == OP_ILLEGAL) begin
            illegal_q <= 1'b1;
        end else if (apb_wr && paddr == OFS_STATUS && pwdata[STAT_ILLEGAL_BIT]) begin
            illegal_q <= 1'b0;
        end
    end

endmodule : bit_branch_loop_cpu_control
`default_nettype wire

// >>> hdl/exec_pkg.sv
// Constants and types for the bit-branch, loop and CPU control execution block
package exec_pkg;

    // ****************************************
    // APB register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;
    localparam logic [7:0] OFS_REGS = 8'h0C;
    localparam logic [7:0] SADDR_BASE = 8'h20;
    localparam logic [7:0] SFR_BASE = 8'h40;
    localparam logic [7:0] MEM_REGION_MASK = 8'hE0;
    localparam int MEM_DEPTH = 8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_HALT_BIT = 1;
    localparam int STAT_STOP_BIT = 2;
    localparam int STAT_IEN_BIT = 3;
    localparam int STAT_ILLEGAL_BIT = 4;
    localparam int REGS_B_LSB = 8;
    localparam int REGS_C_LSB = 16;
    localparam int REGS_PSB_LSB = 24;
    localparam int PSB_IEN_BIT = 7;
    localparam int PSB_Z_BIT = 6;
    localparam int PSB_AUX_BIT = 4;
    localparam int PSB_CRY_BIT = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MEM_RESET = 8'h00;

    // ****************************************
    // Opcodes and instruction lengths
    // ****************************************
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_IEN = 8'h01;
    localparam logic [7:0] OPC_IDS = 8'h02;
    localparam logic [7:0] OPC_HALT = 8'h03;
    localparam logic [7:0] OPC_STOP = 8'h04;
    localparam logic [7:0] OPC_LOOP_B = 8'h05;
    localparam logic [7:0] OPC_LOOP_C = 8'h06;
    localparam logic [7:0] OPC_LOOP_SADDR = 8'h07;
    localparam logic [7:0] OPC_BIT_PREFIX = 8'h31;
    localparam logic [4:0] SUB_BCLR_SADDR = 5'h01;
    localparam logic [4:0] SUB_BCLR_SFR = 5'h02;
    localparam logic [4:0] SUB_BCLR_A = 5'h03;
    localparam logic [4:0] SUB_BCLR_PSB = 5'h04;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_TWO = 3'h2;
    localparam logic [2:0] LEN_THREE = 3'h3;
    localparam logic [2:0] LEN_FOUR = 3'h4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_FETCH = 5'b00010,
        ST_EXEC = 5'b00100,
        ST_HALT = 5'b01000,
        ST_STOP = 5'b10000
    } state_t;

    typedef enum logic [3:0] {
        OP_NOP, OP_IEN, OP_IDS, OP_HALT, OP_STOP,
        OP_BCLR_SADDR, OP_BCLR_SFR, OP_BCLR_A, OP_BCLR_PSB,
        OP_LOOP_B, OP_LOOP_C, OP_LOOP_SADDR, OP_ILLEGAL
    } op_t;

endpackage : exec_pkg

// >>> hdl/inst_decode.sv
// Opcode decoder: instruction class and length in bytes
`timescale 1ns/1ns
`default_nettype none
module inst_decode
    import exec_pkg::*;
(
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    output var op_t op,
    output logic [2:0] len
);

    always_comb begin
        op = OP_ILLEGAL;
        len = LEN_ONE;
        case (b0)
            OPC_NOP: op = OP_NOP;
            OPC_IEN: op = OP_IEN;
            OPC_IDS: op = OP_IDS;
            OPC_HALT: op = OP_HALT;
            OPC_STOP: op = OP_STOP;
            OPC_LOOP_B: begin
                op = OP_LOOP_B;
                len = LEN_TWO;
            end
            OPC_LOOP_C: begin
                op = OP_LOOP_C;
                len = LEN_TWO;
            end
            OPC_LOOP_SADDR: begin
                op = OP_LOOP_SADDR;
                len = LEN_THREE;
            end
            OPC_BIT_PREFIX: begin
                len = LEN_FOUR;
                case (b1[7:3])
                    SUB_BCLR_SADDR: op = OP_BCLR_SADDR;
                    SUB_BCLR_SFR: op = OP_BCLR_SFR;
                    SUB_BCLR_PSB: op = OP_BCLR_PSB;
                    SUB_BCLR_A: begin
                        op = OP_BCLR_A;
                        len = LEN_THREE;
                    end
                    default: begin
                        op = OP_ILLEGAL;
                        len = LEN_TWO;
                    end
                endcase
            end
            default: begin
                op = OP_ILLEGAL;
                len = LEN_ONE;
            end
        endcase
    end

endmodule : inst_decode
`default_nettype wire

// >>> test/bit_branch_loop_cpu_control_tb.sv
// Self-checking bench for the execution block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bit_branch_loop_cpu_control_tb import exec_pkg::*; ();
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, int_ack, nmi_ack, cpu_clk_stop, osc_stop;
    logic [15:0] prog_addr;
    logic [7:0] prog_data;
    logic int_req = 1'b0;
    logic nmi_req = 1'b0;
    logic load_en = 1'b0;
    logic [7:0] load_addr = 8'h00;
    logic [7:0] load_data = 8'h00;
    logic [31:0] rdv;
    logic errv;
    logic [7:0] prg[$];
    int n_fail = 0;
    int checks = 0;
    int n_int = 0;
    int n_nmi = 0;

    always #25 core_clk = ~core_clk;

    bit_branch_loop_cpu_control dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_data(prog_data), .int_req(int_req), .nmi_req(nmi_req), .int_ack(int_ack),
        .nmi_ack(nmi_ack), .cpu_clk_stop(cpu_clk_stop), .osc_stop(osc_stop));
    prog_rom rom (.core_clk(core_clk), .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
        .addr(prog_addr), .data(prog_data));

    // Requests drop once acknowledged
    always @(posedge core_clk) begin
        if (int_ack === 1'b1) begin
            int_req <= 1'b0;
            n_int++;
        end
        if (nmi_ack === 1'b1) begin
            nmi_req <= 1'b0;
            n_nmi++;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            conclude();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_prog(input logic [31:0] regs);
        int k;
        foreach (prg[i]) begin
            @(posedge core_clk);
            load_en <= 1'b1;
            load_addr <= 8'(i);
            load_data <= prg[i];
        end
        @(posedge core_clk);
        load_en <= 1'b0;
        apb(1'b1, OFS_PC, 32'h0);
        apb(1'b1, OFS_REGS, regs);
        apb(1'b1, OFS_CTRL, 32'h1);
        for (k = 0; k < 3000; k++) begin
            @(posedge core_clk);
            if (cpu_clk_stop === 1'b1 || osc_stop === 1'b1) break;
        end
        if (k == 3000) begin
            n_fail++;
            conclude();
        end
    endtask : run_prog

    task automatic wake();
        apb(1'b1, OFS_CTRL, 32'h2);
        repeat (2) @(posedge core_clk);
    endtask : wake

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdv, 32'h0)
        apb(1'b0, OFS_REGS, 32'h0);
        `CHK(rdv, 32'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(errv, 1'b1)
        $display("test reset done");

        prg = {8'h00, 8'h05, 8'hFE, 8'h06, 8'h02, 8'h03, 8'h03, 8'h07, 8'h03, 8'h00, 8'h03};
        apb(1'b1, SADDR_BASE + 8'h0C, 32'h1);
        run_prog(32'h5100_0300);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdv[2:0], 3'b011)
        apb(1'b1, OFS_PC, 32'h0);
        `CHK(errv, 1'b1)
        wake();
        apb(1'b0, OFS_PC, 32'h0);
        `CHK(rdv, 32'h0000_000B)
        `CHK(prog_addr, 16'h000B)
        apb(1'b0, OFS_REGS, 32'h0);
        `CHK(rdv, 32'h51FF_0000)
        apb(1'b0, SADDR_BASE + 8'h0C, 32'h0);
        `CHK(rdv, 32'h0)
        $display("test loop done");

        prg = {8'h31, 8'h19, 8'h05, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h31, 8'h18, 8'h05,
               8'h31, 8'h0F, 8'h01, 8'h7F, 8'h31, 8'h12, 8'h02, 8'h01, 8'h03, 8'h31, 8'h20, 8'h00, 8'h02,
               8'h31, 8'h26, 8'h00, 8'h01, 8'h03, 8'h03};
        apb(1'b1, SADDR_BASE + 8'h04, 32'h80);
        apb(1'b1, SFR_BASE + 8'h08, 32'hFB);
        run_prog(32'h0100_0005);
        wake();
        apb(1'b0, OFS_PC, 32'h0);
        `CHK(rdv, 32'h0000_001E)
        apb(1'b0, OFS_REGS, 32'h0);
        `CHK(rdv, 32'h0100_0005)
        $display("test bit branch done");

        prg = {8'h00, 8'h01, 8'h03};
        n_int = 0;
        int_req <= 1'b1;
        run_prog(32'h0);
        `CHK(n_int, 1)
        wake();
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdv[STAT_IEN_BIT], 1'b1)
        prg = {8'h02, 8'h03};
        n_int = 0;
        int_req <= 1'b1;
        run_prog(32'h8000_0000);
        repeat (4) @(posedge core_clk);
        `CHK(n_int, 0)
        wake();
        int_req <= 1'b0;
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdv[STAT_IEN_BIT], 1'b0)
        prg = {8'h00, 8'h03};
        nmi_req <= 1'b1;
        run_prog(32'h0);
        `CHK(n_nmi, 1)
        wake();
        $display("test interrupts done");

        prg = {8'h04};
        run_prog(32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rdv[2:0], 3'b101)
        `CHK(cpu_clk_stop, 1'b0)
        wake();
        `CHK(osc_stop, 1'b0)
        $display("test stop done");
        conclude();
    end
endmodule : bit_branch_loop_cpu_control_tb

bind bit_branch_loop_cpu_control exec_monitor mon (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .int_req(int_req), .nmi_req(nmi_req),
    .int_ack(int_ack), .nmi_ack(nmi_ack), .cpu_clk_stop(cpu_clk_stop), .osc_stop(osc_stop));
`default_nettype wire

// >>> test/exec_monitor.sv
// Port-level assertions for the execution block
`timescale 1ns/1ns
`default_nettype none
module exec_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic int_req,
    input wire logic nmi_req,
    input wire logic int_ack,
    input wire logic nmi_ack,
    input wire logic cpu_clk_stop,
    input wire logic osc_stop
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_ready_after_setup; s_setup |=> pready; endproperty
    property p_ready_one; pready |=> !pready; endproperty
    property p_err_in_access; pslverr |-> s_access; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_int_cause; int_ack |-> $past(int_req); endproperty
    property p_int_pulse; int_ack |=> !int_ack; endproperty
    property p_nmi_cause; nmi_ack |-> $past(nmi_req); endproperty
    property p_modes_excl; !(cpu_clk_stop && osc_stop); endproperty
    property p_halt_frozen; cpu_clk_stop && $past(cpu_clk_stop) |-> $stable(prog_addr); endproperty
    property p_stop_frozen;
        osc_stop && $past(osc_stop) |-> $stable(prog_addr) && !int_ack && !nmi_ack;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    a_ready_one: assert property (p_ready_one) else $error("ready held too long");
    a_err_in_access: assert property (p_err_in_access) else $error("error outside access");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_int_cause: assert property (p_int_cause) else $error("ack without request");
    a_int_pulse: assert property (p_int_pulse) else $error("ack longer than one cycle");
    a_nmi_cause: assert property (p_nmi_cause) else $error("nmi ack without request");
    a_modes_excl: assert property (p_modes_excl) else $error("halt and stop together");
    a_halt_frozen: assert property (p_halt_frozen) else $error("fetch moved in halt");
    a_stop_frozen: assert property (p_stop_frozen) else $error("activity in stop");
endmodule : exec_monitor
`default_nettype wire

// >>> test/prog_rom.sv
// Program memory model, combinational read, loaded by the bench
`timescale 1ns/1ns
`default_nettype none
module prog_rom (
    input wire logic core_clk,
    input wire logic load_en,
    input wire logic [7:0] load_addr,
    input wire logic [7:0] load_data,
    input wire logic [15:0] addr,
    output logic [7:0] data
);
    logic [7:0] mem [256];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge core_clk) begin
        if (load_en) mem[load_addr] <= load_data;
    end
    // Outside the loaded page reads as halt
    assign data = (addr[15:8] == 8'h00) ? mem[addr[7:0]] : 8'h03;
endmodule : prog_rom
`default_nettype wire
